/* ost_channel.sv */
// One timer channel in one-count mode: load on start, count down, interrupt at the end
module ost_channel #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             enable,
    input  wire logic             one_count,
    input  wire logic             restart_ok,
    input  wire logic             start,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] data,
    output logic                  irq,
    output logic                  busy,
    output logic [CNT_W-1:0]      count
);
    typedef struct packed {
        ost_pkg::ost_ch_state_e state;
        logic [CNT_W-1:0]       count;
        logic                   irq;
    } ost_ch_s;

    if (CNT_W < 2) begin : g_bad_cnt
        $error("CNT_W must be at least 2");
    end

    ost_ch_s q;
    ost_ch_s d;

    always_comb begin
        d     = q;
        d.irq = 1'b0;
        case (q.state)
            ost_pkg::OST_IDLE: begin
                if (enable && one_count && start) begin
                    // A zero load ends the count at once, giving the no-delay start
                    if (data == '0) begin
                        d.irq = 1'b1;
                    end else begin
                        d.count = data;
                        d.state = ost_pkg::OST_COUNTING;
                    end
                end
            end
            ost_pkg::OST_COUNTING: begin
                if (!enable || !one_count) begin
                    d.state = ost_pkg::OST_IDLE;
                end else if (start && restart_ok) begin
                    d.irq   = 1'b1;
                    d.count = data;
                    d.state = (data == '0) ? ost_pkg::OST_IDLE : ost_pkg::OST_COUNTING;
                end else if (tick) begin
                    d.count = q.count - CNT_W'(1);
                    if (q.count == CNT_W'(1)) begin
                        d.irq   = 1'b1;
                        d.state = ost_pkg::OST_IDLE;
                    end
                end
            end
            default: begin
                d.state = ost_pkg::OST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign irq   = q.irq;
    assign busy  = (q.state == ost_pkg::OST_COUNTING);
    assign count = q.count;
endmodule

/* ost_defs_svh_defs.svh */
// Register map, field positions, reset values and clock figures of the one-shot timer
`ifndef OST_DEFS_SVH
`define OST_DEFS_SVH

`define OST_ADDR_W          4
`define OST_REG_CLK_GATE    4'h0
`define OST_REG_PRESCALE    4'h1
`define OST_REG_MODE_M      4'h2
`define OST_REG_MODE_S      4'h3
`define OST_REG_DATA_M      4'h4
`define OST_REG_DATA_S      4'h5
`define OST_REG_START       4'h6
`define OST_REG_STOP        4'h7
`define OST_REG_ENABLE      4'h8
`define OST_REG_OUT_CTRL    4'h9
`define OST_REG_COUNT_M     4'hA
`define OST_REG_COUNT_S     4'hB

`define OST_GATE_BIT        0
`define OST_PRS0_MSB        3
`define OST_PRS0_LSB        0
`define OST_PRS1_MSB        7
`define OST_PRS1_LSB        4
`define OST_PRS2_MSB        9
`define OST_PRS2_LSB        8
`define OST_PRS3_MSB        13
`define OST_PRS3_LSB        12
`define OST_PRESCALE_MASK   16'h33FF

`define OST_CKS_MSB         15
`define OST_CKS_LSB         14
`define OST_CCS_BIT         12
`define OST_STS_MSB         10
`define OST_STS_LSB         8
`define OST_MD_MSB          3
`define OST_MD_HI_LSB       1
`define OST_MD_LOW_BIT      0
`define OST_MODE_MASK       16'hD7CF
`define OST_MD_ONE_COUNT    3'h4
`define OST_STS_SOFTWARE    3'h0
`define OST_STS_MASTER      3'h4
`define OST_CKS_CK0         2'h0
`define OST_CKS_CK2         2'h1
`define OST_CKS_CK1         2'h2
`define OST_CKS_CK3         2'h3

`define OST_CH_MASTER_BIT   0
`define OST_CH_SLAVE_BIT    3
`define OST_OUT_MODE_BIT    0
`define OST_OUT_EN_BIT      1
`define OST_OUT_SW_BIT      2

`define OST_GATE_RESET      8'h00
`define OST_WORD_RESET      16'h0000

`define OST_SRC_CLK_HZ      32000000
`define OST_PULSE_WIDTH     16'h1900

`endif

/* ost_one_shot_timer.sv */
// Two-channel one-shot pulse timer: register port, clock gate, prescaler, trigger routing and pulse pin
`include "ost_defs_svh_defs.svh"

module ost_one_shot_timer #(
    parameter int CNT_W  = 16,
    parameter int DIV_W  = 16,
    parameter int SRC_HZ = `OST_SRC_CLK_HZ
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [`OST_ADDR_W-1:0] reg_addr,
    input  wire ost_pkg::ost_word_t     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output ost_pkg::ost_word_t          reg_rdata,
    input  wire logic                  master_count_in,
    input  wire logic                  slave_count_in,
    output logic                       master_channel_irq,
    output logic                       slave_channel_irq,
    output logic                       slave_pulse_output
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
        $error("CNT_W must lie between 2 and 16");
    end
    if (DIV_W < 16) begin : g_bad_div
        $error("DIV_W must be at least 16 to serve prescale code 15");
    end
    if (SRC_HZ <= 0) begin : g_bad_hz
        $error("SRC_HZ must be positive");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         gate;
        ost_pkg::ost_word_t prescale;
        ost_pkg::ost_word_t mode_m;
        ost_pkg::ost_word_t mode_s;
        ost_pkg::ost_word_t data_m;
        ost_pkg::ost_word_t data_s;
        logic               en_m;
        logic               en_s;
        logic               out_mode;
        logic               out_en;
        logic               out_sw;
        logic               pulse;
        logic               mpin;
        logic               spin;
        ost_pkg::ost_word_t rdata;
    } ost_top_s;

    localparam ost_top_s RESET_STATE = '{
        gate:     `OST_GATE_RESET,
        prescale: `OST_WORD_RESET,
        mode_m:   `OST_WORD_RESET,
        mode_s:   `OST_WORD_RESET,
        data_m:   `OST_WORD_RESET,
        data_s:   `OST_WORD_RESET,
        en_m:     1'b0,
        en_s:     1'b0,
        out_mode: 1'b0,
        out_en:   1'b0,
        out_sw:   1'b0,
        pulse:    1'b0,
        mpin:     1'b0,
        spin:     1'b0,
        rdata:    `OST_WORD_RESET
    };

    ost_top_s           q;
    ost_top_s           d;

    logic               run;
    logic               unit_wr;
    logic               sw_start_m;
    logic               sw_start_s;
    logic               sw_stop_m;
    logic               sw_stop_s;
    logic               m_start;
    logic               s_start;
    logic               m_tick;
    logic               s_tick;
    logic               m_one_count;
    logic               s_one_count;
    logic [2:0]         m_sts;
    logic [2:0]         s_sts;
    ost_pkg::ost_tick_t ck;
    logic               m_irq;
    logic               s_irq;
    logic               m_busy;
    logic               s_busy;
    logic [CNT_W-1:0]   m_count;
    logic [CNT_W-1:0]   s_count;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic opclock(input logic [1:0] cks, input ost_pkg::ost_tick_t t);
        logic sel;
        sel = 1'b0;
        case (cks)
            `OST_CKS_CK0: sel = t[0];
            `OST_CKS_CK2: sel = t[2];
            `OST_CKS_CK1: sel = t[1];
            `OST_CKS_CK3: sel = t[3];
            default:      sel = 1'b0;
        endcase
        return sel;
    endfunction

    // ----------------------------------------------------------------
    // Clock gate and prescaler
    // ----------------------------------------------------------------
    // Gating is done as an enable on register writes, the prescaler, the starts and pin counting instead of a real clock gate,
    // so the unit stays on the single system clock.
    assign run = q.gate[`OST_GATE_BIT];

    ost_prescaler #(
        .DIV_W (DIV_W)
    ) u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (run),
        .select  (q.prescale),
        .tick    (ck)
    );

    // ----------------------------------------------------------------
    // Software triggers
    // ----------------------------------------------------------------
    // Writes to the timer registers need the unit clock, so they are dropped while gated off
    assign unit_wr    = reg_wr && run;
    assign sw_start_m = unit_wr && (reg_addr == `OST_REG_START) && reg_wdata[`OST_CH_MASTER_BIT];
    assign sw_start_s = unit_wr && (reg_addr == `OST_REG_START) && reg_wdata[`OST_CH_SLAVE_BIT];
    assign sw_stop_m  = unit_wr && (reg_addr == `OST_REG_STOP) && reg_wdata[`OST_CH_MASTER_BIT];
    assign sw_stop_s  = unit_wr && (reg_addr == `OST_REG_STOP) && reg_wdata[`OST_CH_SLAVE_BIT];

    assign m_sts       = q.mode_m[`OST_STS_MSB:`OST_STS_LSB];
    assign s_sts       = q.mode_s[`OST_STS_MSB:`OST_STS_LSB];
    assign m_one_count = (q.mode_m[`OST_MD_MSB:`OST_MD_HI_LSB] == `OST_MD_ONE_COUNT);
    assign s_one_count = (q.mode_s[`OST_MD_MSB:`OST_MD_HI_LSB] == `OST_MD_ONE_COUNT);

    // ----------------------------------------------------------------
    // Start routing
    // ----------------------------------------------------------------
    // The master only accepts the software trigger; a master-interrupt source on
    // the master itself would be a loop and is treated as no trigger.
    assign m_start = run && (m_sts == `OST_STS_SOFTWARE) && sw_start_m;

    always_comb begin
        s_start = 1'b0;
        case (s_sts)
            `OST_STS_SOFTWARE: s_start = sw_start_s;
            `OST_STS_MASTER:   s_start = m_irq && q.en_s;
            default:           s_start = 1'b0;
        endcase
        s_start = s_start && run;
    end

    // ----------------------------------------------------------------
    // Count clocks
    // ----------------------------------------------------------------
    // Pin counting uses rising edges only; the pins are taken as synchronous
    always_comb begin
        if (!q.mode_m[`OST_CCS_BIT]) begin
            m_tick = opclock(q.mode_m[`OST_CKS_MSB:`OST_CKS_LSB], ck);
        end else begin
            m_tick = run && master_count_in && !q.mpin;
        end
        if (!q.mode_s[`OST_CCS_BIT]) begin
            s_tick = opclock(q.mode_s[`OST_CKS_MSB:`OST_CKS_LSB], ck);
        end else begin
            s_tick = run && slave_count_in && !q.spin;
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    ost_channel #(
        .CNT_W (CNT_W)
    ) u_master (
        .clk        (clk),
        .reset_n    (reset_n),
        .enable     (d.en_m),
        .one_count  (m_one_count),
        .restart_ok (q.mode_m[`OST_MD_LOW_BIT]),
        .start      (m_start),
        .tick       (m_tick),
        .data       (q.data_m[CNT_W-1:0]),
        .irq        (m_irq),
        .busy       (m_busy),
        .count      (m_count)
    );

    ost_channel #(
        .CNT_W (CNT_W)
    ) u_slave (
        .clk        (clk),
        .reset_n    (reset_n),
        .enable     (d.en_s),
        .one_count  (s_one_count),
        .restart_ok (q.mode_s[`OST_MD_LOW_BIT]),
        .start      (s_start),
        .tick       (s_tick),
        .data       (q.data_s[CNT_W-1:0]),
        .irq        (s_irq),
        .busy       (s_busy),
        .count      (s_count)
    );

    // ----------------------------------------------------------------
    // Next state: registers, enables, pulse pin, read port
    // ----------------------------------------------------------------
    always_comb begin
        d       = q;
        d.mpin  = master_count_in;
        d.spin  = slave_count_in;
        d.rdata = `OST_WORD_RESET;

        // The gate register itself is always writable, or the unit could never wake
        if (reg_wr && reg_addr == `OST_REG_CLK_GATE) begin
            d.gate = reg_wdata[7:0];
        end
        if (unit_wr) begin
            case (reg_addr)
                `OST_REG_PRESCALE: d.prescale = reg_wdata & `OST_PRESCALE_MASK;
                `OST_REG_MODE_M:   d.mode_m   = reg_wdata & `OST_MODE_MASK;
                `OST_REG_MODE_S:   d.mode_s   = reg_wdata & `OST_MODE_MASK;
                `OST_REG_DATA_M:   d.data_m   = reg_wdata;
                `OST_REG_DATA_S:   d.data_s   = reg_wdata;
                `OST_REG_OUT_CTRL: begin
                    d.out_mode = reg_wdata[`OST_OUT_MODE_BIT];
                    d.out_en   = reg_wdata[`OST_OUT_EN_BIT];
                    d.out_sw   = reg_wdata[`OST_OUT_SW_BIT];
                end
                default: begin
                end
            endcase
        end

        // Enable status: a start in the same write as a stop wins
        if (sw_stop_m) begin
            d.en_m = 1'b0;
        end
        if (sw_start_m) begin
            d.en_m = 1'b1;
        end
        if (sw_stop_s) begin
            d.en_s = 1'b0;
        end
        if (sw_start_s) begin
            d.en_s = 1'b1;
        end

        // Pulse pin. A set and reset in one cycle leaves the pin high,
        // because the master interrupt also restarts the slave.
        if (!q.out_en) begin
            d.pulse = q.out_sw;
        end else if (q.out_mode) begin
            if (m_irq && run) begin
                d.pulse = 1'b1;
            end else if (s_irq) begin
                d.pulse = 1'b0;
            end
        end else if (s_irq) begin
            d.pulse = !q.pulse;
        end

        if (reg_rd) begin
            case (reg_addr)
                `OST_REG_CLK_GATE: d.rdata = {8'h00, q.gate};
                `OST_REG_PRESCALE: d.rdata = q.prescale;
                `OST_REG_MODE_M:   d.rdata = q.mode_m;
                `OST_REG_MODE_S:   d.rdata = q.mode_s;
                `OST_REG_DATA_M:   d.rdata = q.data_m;
                `OST_REG_DATA_S:   d.rdata = q.data_s;
                `OST_REG_ENABLE: begin
                    d.rdata[`OST_CH_MASTER_BIT] = q.en_m;
                    d.rdata[`OST_CH_SLAVE_BIT]  = q.en_s;
                end
                `OST_REG_OUT_CTRL: begin
                    d.rdata[`OST_OUT_MODE_BIT] = q.out_mode;
                    d.rdata[`OST_OUT_EN_BIT]   = q.out_en;
                    d.rdata[`OST_OUT_SW_BIT]   = q.out_sw;
                    d.rdata[`OST_CH_SLAVE_BIT + 4] = s_busy;
                    d.rdata[`OST_CH_MASTER_BIT + 4] = m_busy;
                end
                `OST_REG_COUNT_M:  d.rdata = 16'(m_count);
                `OST_REG_COUNT_S:  d.rdata = 16'(s_count);
                default:           d.rdata = `OST_WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata          = q.rdata;
    assign master_channel_irq = m_irq;
    assign slave_channel_irq  = s_irq;
    assign slave_pulse_output = q.pulse;
endmodule

/* ost_one_shot_timer_props.sv */
// Port-level assertions of the one-shot timer
`include "ost_defs_svh_defs.svh"
module ost_one_shot_timer_props (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic [`OST_ADDR_W-1:0] reg_addr,
    input wire ost_pkg::ost_word_t     reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire ost_pkg::ost_word_t     reg_rdata,
    input wire logic                   master_channel_irq,
    input wire logic                   slave_channel_irq,
    input wire logic                   slave_pulse_output
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // Settings shadow
    // ------------
    typedef struct packed {
        logic [7:0]         gate;
        ost_pkg::ost_word_t mode_m;
        ost_pkg::ost_word_t data_m;
        logic [1:0]         out;
    } ost_shadow_s;
    ost_shadow_s sh_q;
    ost_shadow_s sh_d;
    logic        start_m;
    logic        out3;
    logic        m_fast;
    // Writes other than to the gate register are dropped while the unit clock is off, so the shadow drops them too
    always_comb begin
        sh_d = sh_q;
        if (reg_wr && (sh_q.gate[`OST_GATE_BIT] || reg_addr == `OST_REG_CLK_GATE)) begin
            case (reg_addr)
                `OST_REG_CLK_GATE: sh_d.gate = reg_wdata[7:0];
                `OST_REG_MODE_M:   sh_d.mode_m = reg_wdata & `OST_MODE_MASK;
                `OST_REG_DATA_M:   sh_d.data_m = reg_wdata;
                `OST_REG_OUT_CTRL: sh_d.out = reg_wdata[1:0];
                default:           sh_d = sh_q;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        sh_q <= reset_n ? sh_d : '0;
    end
    assign start_m = reg_wr && reg_addr == `OST_REG_START && reg_wdata[`OST_CH_MASTER_BIT];
    assign out3 = sh_q.out == 2'b11;
    assign m_fast = sh_q.gate[0] && sh_q.mode_m[3:1] == `OST_MD_ONE_COUNT && sh_q.mode_m[10:8] == 3'h0
                    && sh_q.data_m == 16'h0000;
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_rd_gate;
        $past(reg_rd && reg_addr == `OST_REG_CLK_GATE) |-> reg_rdata == {8'h00, $past(sh_q.gate)};
    endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("gate readback wrong");
    property p_m_zero;
        start_m && m_fast |=> master_channel_irq;
    endproperty
    a_m_zero: assert property (p_m_zero) else $error("master irq late");
    property p_m_stop;
        master_channel_irq && !start_m |=> !master_channel_irq;
    endproperty
    a_m_stop: assert property (p_m_stop) else $error("master kept running");
    property p_pulse_set;
        $rose(slave_pulse_output) && out3 && $past(out3) |-> $past(master_channel_irq);
    endproperty
    a_pulse_set: assert property (p_pulse_set) else $error("pulse rose without master irq");
    property p_pulse_clr;
        slave_channel_irq && out3 && !master_channel_irq |=> !slave_pulse_output;
    endproperty
    a_pulse_clr: assert property (p_pulse_clr) else $error("pulse not cleared");
    property p_pulse_fall;
        $fell(slave_pulse_output) && out3 && $past(out3) |-> $past(slave_channel_irq);
    endproperty
    a_pulse_fall: assert property (p_pulse_fall) else $error("pulse fell without slave irq");
    property p_gate_off;
        !sh_q.gate[0] && $past(!sh_q.gate[0]) |-> !master_channel_irq && !slave_channel_irq;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("irq with unit clock off");
endmodule

/* ost_one_shot_timer_tb_top.sv */
// Self-checking testbench of the one-shot timer
`include "ost_defs_svh_defs.svh"
module ost_one_shot_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int                 LIMIT = 7000;
    localparam ost_pkg::ost_word_t MODES [5] = '{16'h0408, 16'h0408, 16'h8408, 16'h4408, 16'hC408};
    localparam ost_pkg::ost_word_t PRES [5]  = '{16'h0000, 16'h0003, 16'h0020, 16'h0100, 16'h3000};
    localparam int                 DIVS [5]  = '{1, 8, 4, 2, 8};
    logic                   clk;
    logic                   reset_n;
    logic [`OST_ADDR_W-1:0] reg_addr;
    ost_pkg::ost_word_t     reg_wdata;
    ost_pkg::ost_word_t     reg_rdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic                   master_channel_irq;
    logic                   slave_channel_irq;
    logic                   slave_pulse_output;
    logic                   master_count_in;
    logic                   slave_count_in;
    int                     fails;
    int                     n_tests;
    // Master count pin is pulsed only in the pin-count run; the slave pin idles low
    ost_one_shot_timer dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .master_count_in, .slave_count_in, .master_channel_irq, .slave_channel_irq,
        .slave_pulse_output);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ------------
    // Tasks
    // ------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string what, input ost_pkg::ost_word_t exp, input ost_pkg::ost_word_t got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input logic [`OST_ADDR_W-1:0] a, input ost_pkg::ost_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [`OST_ADDR_W-1:0] a, input ost_pkg::ost_word_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_word($sformatf("register %h", a), exp, reg_rdata);
    endtask
    task automatic wait_irq(input logic slave, output int n);
        n = 0;
        #1;
        while ((slave ? slave_channel_irq : master_channel_irq) !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > LIMIT) begin
                fails++;
                tally_and_finish();
            end
        end
    endtask
    task automatic pulse_run(input ost_pkg::ost_word_t md, input ost_pkg::ost_word_t pre,
                             input ost_pkg::ost_word_t width, input int div);
        int n;
        int w;
        w = int'(width);
        wr(`OST_REG_PRESCALE, pre);
        wr(`OST_REG_MODE_S, md);
        wr(`OST_REG_DATA_S, width);
        wr(`OST_REG_START, 16'h0009);
        #1;
        chk_bit("master irq", 1'b1, master_channel_irq);
        @(posedge clk);
        #1;
        chk_bit("pulse set", 1'b1, slave_pulse_output);
        chk_bit("master irq end", 1'b0, master_channel_irq);
        wait_irq(1'b1, n);
        chk_bit("pulse width", 1'b1, n >= (w - 1) * div + 1 && n <= w * div);
        @(posedge clk);
        #1;
        chk_bit("pulse clear", 1'b0, slave_pulse_output);
    endtask
    // ------------
    // Sequence
    // ------------
    initial begin
        int n;
        fails = 0;
        n_tests = 0;
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        master_count_in = 1'b0;
        slave_count_in = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
        wr(`OST_REG_MODE_M, 16'h0008);
        rd(`OST_REG_MODE_M, 16'h0000);
        wr(`OST_REG_CLK_GATE, 16'h0001);
        rd(`OST_REG_CLK_GATE, 16'h0001);
        wr(`OST_REG_MODE_M, 16'hFFFF);
        rd(`OST_REG_MODE_M, `OST_MODE_MASK);
        wr(`OST_REG_MODE_M, 16'h0008);
        wr(`OST_REG_OUT_CTRL, 16'h0003);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        for (int i = 0; i < 5; i++) pulse_run(MODES[i], PRES[i], 16'h0003, DIVS[i]);
        rd(`OST_REG_ENABLE, 16'h0009);
        pulse_run(16'h0408, 16'h0000, `OST_PULSE_WIDTH, 1);
        wr(`OST_REG_DATA_M, 16'h000A);
        wr(`OST_REG_START, 16'h0001);
        wr(`OST_REG_START, 16'h0001);
        wait_irq(1'b0, n);
        chk_bit("restart ignored", 1'b1, n == 8);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            n += int'(master_channel_irq === 1'b1);
        end
        chk_bit("no extra irq", 1'b1, n == 0);
        rd(`OST_REG_OUT_CTRL, 16'h0083);
        wr(`OST_REG_STOP, 16'h0008);
        rd(`OST_REG_ENABLE, 16'h0001);
        rd(`OST_REG_OUT_CTRL, 16'h0003);
        wr(`OST_REG_MODE_M, 16'h0009);
        wr(`OST_REG_START, 16'h0001);
        wr(`OST_REG_START, 16'h0001);
        #1;
        chk_bit("restart irq", 1'b1, master_channel_irq);
        @(posedge clk);
        wait_irq(1'b0, n);
        chk_bit("restart reload", 1'b1, n == 9);
        wr(`OST_REG_MODE_M, 16'h1008);
        wr(`OST_REG_DATA_M, 16'h0003);
        wr(`OST_REG_START, 16'h0001);
        repeat (3) begin
            @(posedge clk);
            master_count_in <= 1'b1;
            @(posedge clk);
            master_count_in <= 1'b0;
        end
        #1;
        chk_bit("pin count irq", 1'b1, master_channel_irq);
        wr(`OST_REG_OUT_CTRL, 16'h0000);
        @(posedge clk);
        #1;
        chk_bit("software level", 1'b0, slave_pulse_output);
        wr(`OST_REG_CLK_GATE, 16'h0000);
        wr(`OST_REG_DATA_S, 16'h0005);
        rd(`OST_REG_DATA_S, `OST_PULSE_WIDTH);
        tally_and_finish();
    end
endmodule
bind ost_one_shot_timer ost_one_shot_timer_props u_props (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .master_channel_irq, .slave_channel_irq, .slave_pulse_output);

/* ost_pkg.sv */
// Shared types of the one-shot timer
package ost_pkg;
    typedef logic [15:0] ost_word_t;
    typedef logic [3:0]  ost_tick_t;
    typedef enum logic [0:0] {OST_IDLE, OST_COUNTING} ost_ch_state_e;
endpackage

/* ost_prescaler.sv */
// Free-running divider producing the four prescaled clock enables
module ost_prescaler #(
    parameter int DIV_W = 16
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              run,
    input  wire ost_pkg::ost_word_t select,
    output ost_pkg::ost_tick_t     tick
);
    typedef struct packed {
        logic [DIV_W-1:0] div;
    } ost_pre_s;

    if (DIV_W < 16) begin : g_bad_div
        $error("DIV_W must be at least 16 to serve prescale code 15");
    end

    ost_pre_s         q;
    ost_pre_s         d;
    logic [3:0] [3:0] code;

    always_comb begin
        code[0] = select[`OST_PRS0_MSB:`OST_PRS0_LSB];
        code[1] = select[`OST_PRS1_MSB:`OST_PRS1_LSB];
        code[2] = {2'h0, select[`OST_PRS2_MSB:`OST_PRS2_LSB]};
        code[3] = {2'h0, select[`OST_PRS3_MSB:`OST_PRS3_LSB]};
        d       = q;
        if (run) begin
            d.div = q.div + DIV_W'(1);
        end
    end

    // Code n ticks once every 2**n source cycles; code 0 ticks every cycle
    for (genvar i = 0; i < 4; i++) begin : g_tick
        logic [DIV_W-1:0] mask;
        assign mask    = (DIV_W'(1) << code[i]) - DIV_W'(1);
        assign tick[i] = run && ((q.div & mask) == mask);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
